// File: design/drive_pkg.sv
// Constants, states and carriers for the diskette drive status and read path
package drive_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_NS              = 40;
	localparam int INDEX_PULSE_NS      = 1_800_000;
	localparam int INDEX_PULSE_CYCLES  = INDEX_PULSE_NS / CLK_NS;
	localparam int READ_PULSE_NS       = 200;
	localparam int READ_PULSE_CYCLES   = (READ_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int DATA_WINDOW_NS      = 3000;
	localparam int DATA_WINDOW_CYCLES  = DATA_WINDOW_NS / CLK_NS;

	// ------------------------------------------------------------
	// Counts and sizes
	// ------------------------------------------------------------
	localparam logic [1:0] HOLES_ONE_SIDED = 2'h2;
	localparam logic [1:0] HOLES_TWO_SIDED = 2'h3;
	localparam int         FIFO_DEPTH      = 32;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		IDX_EMPTY    = 2'h0,
		IDX_COUNTING = 2'h1,
		IDX_READY    = 2'h3
	} ready_state_type;

	typedef struct packed {
		logic raw_bit;
		logic data_bit;
		logic clock_bit;
	} flux_event_type;

	typedef struct packed {
		logic index_hole;
		logic door_closed;
		logic media_present;
		logic two_sided;
		logic protect_tab;
		logic side_select;
		logic write_gate_n;
		logic drive_select_n;
		logic flux_pulse;
		logic wp_inhibit;
	} pin_sample_type;

	localparam pin_sample_type PINS_IDLE = 10'h0c6;

endpackage

// File: design/drive_status.sv
// Diskette drive ready, index, read pulse, separator and write protect logic
`timescale 1ns/100ps

// ------------------------------------------------------------
// Flux event FIFO
// ------------------------------------------------------------
module flux_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      wr_ptr_next;
	logic [AW:0]      rd_ptr_reg;
	logic [AW:0]      rd_ptr_next;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready    = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
		out_valid   = (wr_ptr_reg != rd_ptr_reg);
		out_data    = mem[rd_ptr_reg[AW-1:0]];
		push        = in_valid && in_ready && !flush;
		pop         = out_valid && out_ready && !flush;
		wr_ptr_next = flush ? '0 : wr_ptr_reg + (AW+1)'(push);
		rd_ptr_next = flush ? '0 : rd_ptr_reg + (AW+1)'(pop);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end
endmodule

// ------------------------------------------------------------
// Drive status top
// ------------------------------------------------------------
module drive_status
	import drive_pkg::*;
#(
	parameter int unsigned INDEX_PULSE_LEN = INDEX_PULSE_CYCLES,
	parameter bit          HAS_SEPARATOR   = 1'b1,
	parameter int          BUF_DEPTH       = FIFO_DEPTH
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic index_hole,
	input  wire logic door_closed,
	input  wire logic media_present,
	input  wire logic two_sided,
	input  wire logic protect_tab,
	input  wire logic side_select,
	input  wire logic write_gate_n,
	input  wire logic drive_select_n,
	input  wire logic flux_pulse,
	input  wire logic wp_inhibit,
	output logic      ready_n,
	output logic      index_n,
	output logic      read_data_n,
	output logic      separated_bit_stream_n,
	output logic      separated_timing_stream_n,
	output logic      write_protect_n,
	output logic      write_enable
);
	localparam int IW = $clog2(INDEX_PULSE_LEN + 1);
	localparam int OW = $clog2(READ_PULSE_CYCLES + 1);
	localparam int WW = $clog2(DATA_WINDOW_CYCLES + 1);

	// ------------------------------------------------------------
	// Pin synchronisers and edge detect
	// ------------------------------------------------------------
	pin_sample_type pins_raw;
	pin_sample_type pins_meta_reg;
	pin_sample_type pins_s_reg;
	pin_sample_type pins_d_reg;
	logic           hole_edge;
	logic           flux_edge;
	logic           selected;
	logic           media_ok;
	logic           read_enable;

	always_comb begin
		pins_raw    = {index_hole, door_closed, media_present, two_sided, protect_tab,
		               side_select, write_gate_n, drive_select_n, flux_pulse, wp_inhibit};
		hole_edge   = pins_s_reg.index_hole && !pins_d_reg.index_hole;
		flux_edge   = pins_s_reg.flux_pulse && !pins_d_reg.flux_pulse;
		selected    = !pins_s_reg.drive_select_n;
		media_ok    = pins_s_reg.door_closed && pins_s_reg.media_present;
		read_enable = pins_s_reg.write_gate_n;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_meta_reg <= PINS_IDLE;
			pins_s_reg    <= PINS_IDLE;
			pins_d_reg    <= PINS_IDLE;
		end else begin
			pins_meta_reg <= pins_raw;
			pins_s_reg    <= pins_meta_reg;
			pins_d_reg    <= pins_s_reg;
		end
	end

	// ------------------------------------------------------------
	// Index hole counting and ready
	// ------------------------------------------------------------
	ready_state_type state_reg;
	ready_state_type state_next;
	logic [1:0]      hole_cnt_reg;
	logic [1:0]      hole_cnt_next;
	logic [1:0]      hole_target;

	always_comb begin
		hole_target   = pins_s_reg.two_sided ? HOLES_TWO_SIDED : HOLES_ONE_SIDED;
		state_next    = state_reg;
		hole_cnt_next = hole_cnt_reg;
		case (state_reg)
			IDX_EMPTY: begin
				hole_cnt_next = 2'h0;
				if (media_ok) begin
					state_next = IDX_COUNTING;
				end
			end
			IDX_COUNTING: begin
				// Saturate so a late hole cannot wrap the count to zero
				if (hole_edge && (hole_cnt_reg != HOLES_TWO_SIDED)) begin
					hole_cnt_next = hole_cnt_reg + 2'h1;
				end
				if (hole_cnt_reg >= hole_target) begin
					state_next = IDX_READY;
				end
			end
			IDX_READY: begin
				if (hole_cnt_reg < hole_target) begin
					state_next = IDX_COUNTING;
				end
			end
			default: begin
				state_next = IDX_EMPTY;
			end
		endcase
		if (!media_ok) begin
			state_next    = IDX_EMPTY;
			hole_cnt_next = 2'h0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= IDX_EMPTY;
			hole_cnt_reg <= 2'h0;
		end else begin
			state_reg    <= state_next;
			hole_cnt_reg <= hole_cnt_next;
		end
	end

	// ------------------------------------------------------------
	// Index pulse stretcher
	// ------------------------------------------------------------
	logic [IW-1:0] index_cnt_reg;
	logic [IW-1:0] index_cnt_next;

	always_comb begin
		index_cnt_next = index_cnt_reg;
		if (hole_edge) begin
			index_cnt_next = IW'(INDEX_PULSE_LEN);
		end else if (index_cnt_reg != '0) begin
			index_cnt_next = index_cnt_reg - IW'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			index_cnt_reg <= '0;
		end else begin
			index_cnt_reg <= index_cnt_next;
		end
	end

	// ------------------------------------------------------------
	// Data separator, drops flux edges while the FIFO is full and one is pending
	// ------------------------------------------------------------
	flux_event_type pend_reg;
	flux_event_type pend_next;
	logic           pend_valid_reg;
	logic           pend_valid_next;
	logic [WW-1:0]  win_cnt_reg;
	logic [WW-1:0]  win_cnt_next;
	logic           after_clock_reg;
	logic           after_clock_next;
	logic           fifo_in_ready;
	logic           is_data;

	always_comb begin
		pend_next        = pend_reg;
		pend_valid_next  = pend_valid_reg;
		after_clock_next = after_clock_reg;
		win_cnt_next     = (win_cnt_reg == WW'(DATA_WINDOW_CYCLES)) ? win_cnt_reg : win_cnt_reg + WW'(1);
		is_data          = after_clock_reg && (win_cnt_reg < WW'(DATA_WINDOW_CYCLES));
		if (pend_valid_reg && fifo_in_ready) begin
			pend_valid_next = 1'b0;
		end
		if (flux_edge && read_enable && (!pend_valid_reg || fifo_in_ready)) begin
			pend_valid_next    = 1'b1;
			pend_next.raw_bit  = 1'b1;
			pend_next.data_bit = HAS_SEPARATOR && is_data;
			pend_next.clock_bit = HAS_SEPARATOR && !is_data;
			after_clock_next   = !is_data;
			if (!is_data) begin
				win_cnt_next = '0;
			end
		end
		if (!read_enable) begin
			pend_valid_next  = 1'b0;
			after_clock_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg        <= '0;
			pend_valid_reg  <= 1'b0;
			win_cnt_reg     <= '0;
			after_clock_reg <= 1'b0;
		end else begin
			pend_reg        <= pend_next;
			pend_valid_reg  <= pend_valid_next;
			win_cnt_reg     <= win_cnt_next;
			after_clock_reg <= after_clock_next;
		end
	end

	// ------------------------------------------------------------
	// Buffer and read pulse generator
	// ------------------------------------------------------------
	flux_event_type fifo_out;
	logic           fifo_out_valid;
	flux_event_type word_reg;
	flux_event_type word_next;
	logic [OW-1:0]  out_cnt_reg;
	logic [OW-1:0]  out_cnt_next;
	logic           drain_ready;

	flux_fifo #(
		.WIDTH ($bits(flux_event_type)),
		.DEPTH (BUF_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.flush     (!read_enable),
		.in_valid  (pend_valid_reg),
		.in_ready  (fifo_in_ready),
		.in_data   (pend_reg),
		.out_valid (fifo_out_valid),
		.out_ready (drain_ready),
		.out_data  (fifo_out)
	);

	always_comb begin
		drain_ready  = (out_cnt_reg == '0);
		word_next    = word_reg;
		out_cnt_next = (out_cnt_reg == '0) ? out_cnt_reg : out_cnt_reg - OW'(1);
		if (drain_ready && fifo_out_valid && read_enable) begin
			word_next    = fifo_out;
			out_cnt_next = OW'(READ_PULSE_CYCLES);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_reg    <= '0;
			out_cnt_reg <= '0;
		end else begin
			word_reg    <= word_next;
			out_cnt_reg <= out_cnt_next;
		end
	end

	// ------------------------------------------------------------
	// Registered, select-gated outputs
	// ------------------------------------------------------------
	logic rd_on;
	logic ready_next;
	logic wr_next;

	always_comb begin
		rd_on      = selected && read_enable && (out_cnt_reg != '0);
		// Count gate covers the cycle in which two-sided media raises the target
		ready_next = selected && (state_reg == IDX_READY) && (hole_cnt_reg >= hole_target)
		             && (pins_s_reg.two_sided || pins_s_reg.side_select);
		wr_next    = selected && !pins_s_reg.write_gate_n
		             && !(pins_s_reg.protect_tab && pins_s_reg.wp_inhibit);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_n                   <= 1'b1;
			index_n                   <= 1'b1;
			read_data_n               <= 1'b1;
			separated_bit_stream_n    <= 1'b1;
			separated_timing_stream_n <= 1'b1;
			write_protect_n           <= 1'b1;
			write_enable              <= 1'b0;
		end else begin
			ready_n                   <= !ready_next;
			index_n                   <= !(selected && (index_cnt_reg != '0));
			read_data_n               <= !(rd_on && word_reg.raw_bit);
			separated_bit_stream_n    <= !(rd_on && word_reg.data_bit);
			separated_timing_stream_n <= !(rd_on && word_reg.clock_bit);
			write_protect_n           <= !(selected && pins_s_reg.protect_tab);
			write_enable              <= wr_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_ready_needs_holes: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ready_n |-> $past(state_reg == IDX_READY))
		else $error("ready asserted before index count done");
	a_powerup_two_holes: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == IDX_READY) |-> (hole_cnt_reg >= HOLES_ONE_SIDED))
		else $error("ready state with fewer than two holes");
	a_two_sided_three: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!ready_n && $past(pins_s_reg.two_sided)) |-> ($past(hole_cnt_reg) == HOLES_TWO_SIDED))
		else $error("two-sided ready with fewer than three holes");
	a_single_side_one: assert property (@(posedge core_clk) disable iff (!rst_n)
		(selected && state_reg == IDX_READY && !pins_s_reg.two_sided)
		|=> (ready_n == !$past(pins_s_reg.side_select)))
		else $error("single-sided ready wrong for selected surface");
	a_two_side_any: assert property (@(posedge core_clk) disable iff (!rst_n)
		(selected && state_reg == IDX_READY && pins_s_reg.two_sided && hole_cnt_reg == HOLES_TWO_SIDED)
		|=> !ready_n)
		else $error("two-sided ready dropped");
	a_raw_pulse_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(read_data_n) |-> $past(out_cnt_reg == OW'(READ_PULSE_CYCLES)))
		else $error("raw read pulse without buffered event");
	a_separated_bit_stream_in_raw: assert property (@(posedge core_clk) disable iff (!rst_n)
		!separated_bit_stream_n |-> (!read_data_n && separated_timing_stream_n))
		else $error("data bit outside raw pulse");
	a_separated_timing_stream_in_raw: assert property (@(posedge core_clk) disable iff (!rst_n)
		!separated_timing_stream_n |-> !read_data_n)
		else $error("clock bit outside raw pulse");
	a_protect_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		(selected && pins_s_reg.protect_tab) |=> !write_protect_n)
		else $error("protect status not reported");
	a_write_inhibit: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pins_s_reg.protect_tab && pins_s_reg.wp_inhibit) |=> !write_enable)
		else $error("write enabled on protected diskette");
	a_index_width: assert property (@(posedge core_clk) disable iff (!rst_n)
		hole_edge |=> (index_cnt_reg == IW'(INDEX_PULSE_LEN)))
		else $error("index pulse length not loaded");
	a_read_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		!read_enable |=> (read_data_n && separated_bit_stream_n && separated_timing_stream_n))
		else $error("read pulse while writing");
	a_deselect_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		!selected |=> (ready_n && index_n && read_data_n && write_protect_n && !write_enable))
		else $error("output active while deselected");
	a_media_removed: assert property (@(posedge core_clk) disable iff (!rst_n)
		!media_ok |=> (state_reg == IDX_EMPTY && hole_cnt_reg == 2'h0) ##1 ready_n)
		else $error("ready kept after media removal");
endmodule

// File: bench/media_model.sv
// Spinning diskette model: index hole sensor and head flux pulses
`timescale 1ns/100ps

module media_model #(
	parameter int HOLE_PERIOD = 60,
	parameter int HOLE_WIDTH  = 4
) (
	input  wire logic core_clk,
	input  wire logic spin,
	input  wire logic flux_req,
	output logic      index_hole,
	output logic      flux_pulse,
	output int        n_holes
);
	int hole_cnt;
	int phase;

	initial begin
		index_hole = 1'b0;
		flux_pulse = 1'b0;
		n_holes = 0;
		hole_cnt = 0;
		phase = 0;
	end

	// ------------------------------------------------------------
	// Index hole once per revolution
	// ------------------------------------------------------------
	always @(negedge core_clk) begin
		if (spin) begin
			index_hole <= (hole_cnt < HOLE_WIDTH);
			hole_cnt <= (hole_cnt + 1) % HOLE_PERIOD;
			if (hole_cnt == 0) begin
				n_holes <= n_holes + 1;
			end
		end else begin
			index_hole <= 1'b0;
			hole_cnt <= 0;
		end
	end

	// ------------------------------------------------------------
	// Flux pulses, two cycles high and two low each
	// ------------------------------------------------------------
	always @(negedge core_clk) begin
		if (flux_req || phase != 0) begin
			flux_pulse <= (phase < 2);
			phase <= (phase + 1) % 4;
		end else begin
			flux_pulse <= 1'b0;
		end
	end
endmodule

// File: bench/test_diskette_drive_status_outputs.sv
// Self-checking bench for the drive status and read path
`timescale 1ns/100ps

module test_diskette_drive_status_outputs;
	localparam int IDX_LEN = 20;
	localparam int PERIOD  = 60;

	typedef struct packed {
		logic ts, side, prot, wg_n, wpi, ds_n, rdy_n, wp_n, we;
	} row_type;

	// ------------------------------------------------------------
	// Level cases: inputs, then ready_n, write_protect_n, write_enable
	// ------------------------------------------------------------
	localparam row_type ROWS [9] = '{
		9'h0b2, 9'h036, 9'h132, 9'h1b2, 9'h0f0,
		9'h0d0, 9'h093, 9'h0c1, 9'h0de
	};

	logic       core_clk, rst_n, door_closed, media_present, two_sided;
	logic       protect_tab, side_select, write_gate_n, drive_select_n;
	logic       wp_inhibit, spin, flux_req;
	logic       index_hole, flux_pulse, ready_n, index_n, read_data_n;
	logic       sbit_n, stime_n, write_protect_n, write_enable;
	logic [3:0] outs, snap;
	int         n_holes, n_fail, n_tests, cyc, len, lows;
	row_type    r;

	assign outs = {index_n, read_data_n, sbit_n, stime_n};

	media_model #(.HOLE_PERIOD(PERIOD), .HOLE_WIDTH(4)) u_media (
		.core_clk(core_clk), .spin(spin), .flux_req(flux_req),
		.index_hole(index_hole), .flux_pulse(flux_pulse), .n_holes(n_holes)
	);

	drive_status #(.INDEX_PULSE_LEN(IDX_LEN), .HAS_SEPARATOR(1'b1), .BUF_DEPTH(32)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .index_hole(index_hole),
		.door_closed(door_closed), .media_present(media_present),
		.two_sided(two_sided), .protect_tab(protect_tab),
		.side_select(side_select), .write_gate_n(write_gate_n),
		.drive_select_n(drive_select_n), .flux_pulse(flux_pulse),
		.wp_inhibit(wp_inhibit), .ready_n(ready_n), .index_n(index_n),
		.read_data_n(read_data_n), .separated_bit_stream_n(sbit_n),
		.separated_timing_stream_n(stime_n),
		.write_protect_n(write_protect_n), .write_enable(write_enable)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		if (n_fail == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Wait for n more index holes, then let ready settle
	task automatic holes(input int n);
		int start;
		int k;
		start = n_holes;
		k = 0;
		while (n_holes < start + n && k < n * PERIOD + 10) begin
			@(negedge core_clk);
			k++;
		end
		cycles(10);
	endtask

	// Low time of output b, outputs captured where it fell
	task automatic low_len(input int b, input int lim);
		int k;
		k = 0;
		len = 0;
		// Skip a pulse already under way, then wait for a fresh fall
		while (outs[b] === 1'b0 && k < lim) begin
			@(negedge core_clk);
			k++;
		end
		while (outs[b] !== 1'b0 && k < lim) begin
			@(negedge core_clk);
			k++;
		end
		snap = outs;
		while (outs[b] === 1'b0 && len < 200) begin
			@(negedge core_clk);
			len++;
		end
	endtask

	task automatic flux_once();
		flux_req <= 1'b1;
		cycles(1);
		flux_req <= 1'b0;
		low_len(2, 15);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, two_sided, spin, flux_req, drive_select_n} = 5'h00;
		{door_closed, media_present, protect_tab, side_select} = 4'hf;
		{write_gate_n, wp_inhibit} = 2'h3;
		cycles(10);
		check({outs, ready_n, write_protect_n, write_enable}, 7'h7e);
		rst_n <= 1'b1;
		cycles(5);
		check(write_protect_n, 1'b0);
		protect_tab <= 1'b0;
		spin <= 1'b1;
		holes(1);
		check(ready_n, 1'b1);
		holes(1);
		check(ready_n, 1'b0);
		foreach (ROWS[i]) begin
			r = ROWS[i];
			{two_sided, side_select, protect_tab} <= {r.ts, r.side, r.prot};
			{write_gate_n, wp_inhibit, drive_select_n} <= {r.wg_n, r.wpi, r.ds_n};
			cycles(2 * PERIOD + 12);
			check({ready_n, write_protect_n, write_enable}, {r.rdy_n, r.wp_n, r.we});
		end
		{two_sided, protect_tab, drive_select_n, write_gate_n} <= 4'h1;
		spin <= 1'b0;
		door_closed <= 1'b0;
		cycles(5);
		check(ready_n, 1'b1);
		door_closed <= 1'b1;
		cycles(5);
		spin <= 1'b1;
		holes(1);
		check(ready_n, 1'b1);
		holes(1);
		check(ready_n, 1'b0);
		spin <= 1'b0;
		media_present <= 1'b0;
		cycles(5);
		check(ready_n, 1'b1);
		{two_sided, media_present} <= 2'h3;
		cycles(5);
		spin <= 1'b1;
		holes(2);
		check(ready_n, 1'b1);
		holes(1);
		check(ready_n, 1'b0);
		low_len(3, PERIOD + 10);
		check(len, IDX_LEN);
		flux_once();
		check(len, 32'h5);
		check(snap[1:0], 2'h2);
		flux_once();
		check(len, 32'h5);
		check(snap[1:0], 2'h1);
		flux_once();
		check(snap[1:0], 2'h2);
		cycles(100);
		flux_once();
		check(snap[1:0], 2'h2);
		write_gate_n <= 1'b0;
		cycles(5);
		flux_once();
		check(len, 0);
		write_gate_n <= 1'b1;
		cycles(5);
		flux_once();
		check(len, 32'h5);
		check(snap[1:0], 2'h2);
		lows = 0;
		flux_req <= 1'b1;
		for (int i = 0; i < 1200; i++) begin
			@(negedge core_clk);
			if (i == 799) begin
				flux_req <= 1'b0;
			end
			if (read_data_n === 1'b0) begin
				lows++;
			end
		end
		check(lows % 5, 0);
		// 200 edges offered faster than drained; a full buffer drops some
		check(lows / 5 >= 160 && lows / 5 <= 175, 1'b1);
		check(read_data_n, 1'b1);
		end_sim();
	end
endmodule
